// ===== rtl/sotp_defines.vh
// Purpose: Shared constants for the security register and quad mode command block.
// Assumes: A 20 MHz system clock.
// Notes: Cycle counts derive from times in microseconds.
`ifndef SOTP_DEFINES_VH
`define SOTP_DEFINES_VH

`define SOTP_OP_ERASE 8'h44
`define SOTP_OP_PROG 8'h42
`define SOTP_OP_READ 8'h48
`define SOTP_OP_RDPAR 8'hC0
`define SOTP_OP_FREAD 8'h0B
`define SOTP_OP_QREAD 8'hEB
`define SOTP_OP_WRAPRD 8'h0C
`define SOTP_OP_QPI_EN 8'h38
`define SOTP_OP_QPI_EX 8'hFF
`define SOTP_OP_BURST 8'h77
`define SOTP_OP_RSTEN 8'h66
`define SOTP_OP_RST 8'h99
`define SOTP_OP_WREN 8'h06
`define SOTP_OP_WRDI 8'h04
`define SOTP_OP_RDSR 8'h05

`define SOTP_SEC_HI 8'h00
`define SOTP_SEC_MID 4'h0
`define SOTP_SEC_R1 4'h1
`define SOTP_SEC_R2 4'h2
`define SOTP_SEC_R3 4'h3
`define SOTP_SEC_DUMMY 4'h8
`define SOTP_ADDR_LAST 2'h2
`define SOTP_ERASED 8'hFF

`define SOTP_DUMMY_DEF 2'h0
`define SOTP_WRAP_DEF 2'h0
`define SOTP_SYNC_RST 6'h01

`define SOTP_CLK_MHZ 20
`define SOTP_SEC_ERASE_US 50
`define SOTP_SEC_ERASE_CYC (`SOTP_SEC_ERASE_US * `SOTP_CLK_MHZ)
`define SOTP_SEC_PROG_US 10
`define SOTP_SEC_PROG_CYC (`SOTP_SEC_PROG_US * `SOTP_CLK_MHZ)
`define SOTP_RST_US 30
`define SOTP_RST_CYC (`SOTP_RST_US * `SOTP_CLK_MHZ)

`define SOTP_FIFO_WIDTH 8
`define SOTP_FIFO_DEPTH 16
`define SOTP_FIFO_AW 4

`endif

// ===== rtl/sotp_core.v
// Purpose: Security register erase, program and read, plus quad mode read setup.
// Assumes: The serial link is sampled by ref_clk_i, at least eight samples per link clock.
// Notes: The main array is outside; it answers arr_addr_o combinationally on arr_data_i.
`include "sotp_defines.vh"

module sotp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and control
    input wire clk_i,
    input wire reset_i,
    input wire en_i,
    input wire flush_i,
    // Fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];

    always @(posedge clk_i) begin
        if (en_i && push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (en_i) begin
            if (flush_i) begin
                wr_ptr <= {AW{1'b0}};
                rd_ptr <= {AW{1'b0}};
                count <= {(AW+1){1'b0}};
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                end
                if (push && !pop) begin
                    count <= count + {{AW{1'b0}}, 1'b1};
                end else if (pop && !push) begin
                    count <= count - {{AW{1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// Functional notes
// - three independent 256-byte security registers.
// - erase opcode 44h needs write latch.
// - address selects register one to three.
// - erase only if select rises on boundary.
// - busy flag set during timed erase.
// - erase completion clears write enable latch.
// - locked register ignores erase and program.
// - program only clears bits, in erased or written bytes.
// - program opcode 42h needs write latch.
// - read 48h, eight dummies, MSB first.
// - read offset wraps within same register.
// - read parameters accepted in quad mode only.
// - dummy field picks 2/4/6/8 clocks.
// - wrap field picks 8/16/32/64 bytes.
// - defaults are 8-byte wrap, 2 dummies.
// - SPI wrap from 77h, kept across switch.
// - wrapped burst read wraps inside window.
// - 38h enters quad mode if enabled.
// - starts in SPI; modes are exclusive.
// - mode switch keeps latch and wrap.
// - FFh or the 66h/99h reset leaves quad mode.
// - 66h then 99h resets defaults.
module sotp_core (
    // Clock, reset and enable
    input wire ref_clk_i,
    input wire reset_i,
    input wire clk_en_i,
    // Serial link pins
    input wire spi_cs_n_i,
    input wire spi_sck_i,
    input wire [3:0] spi_io_i,
    output reg [3:0] spi_io_o,
    output wire [3:0] spi_io_oe_o,
    // Status bits held elsewhere
    input wire quad_enable_bit_i,
    input wire [2:0] otp_lock_bits_i,
    // Main array read port
    output wire [23:0] arr_addr_o,
    output wire arr_rd_o,
    input wire [7:0] arr_data_i,
    // Block state
    output wire busy_o,
    output wire write_enable_latch_o,
    output wire quad_command_mode_o,
    output wire [1:0] dummy_count_field_o,
    output wire [1:0] wrap_len_field_o
);
    localparam ST_CMD = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_DUMMY = 3'h2;
    localparam ST_DIN = 3'h3;
    localparam ST_DOUT = 3'h4;
    localparam ST_DONE = 3'h5;
    localparam ST_IGN = 3'h6;
    localparam M_SEC = 2'h0;
    localparam M_LIN = 2'h1;
    localparam M_WIN = 2'h2;
    localparam OP_ERASE = 2'h0;
    localparam OP_PROG = 2'h1;
    localparam OP_RST = 2'h2;
    localparam [31:0] T_ERASE = `SOTP_SEC_ERASE_CYC;
    localparam [31:0] T_PROG = `SOTP_SEC_PROG_CYC;
    localparam [31:0] T_RST = `SOTP_RST_CYC;
    localparam [5:0] SYNC_INIT = `SOTP_SYNC_RST;

    reg [5:0] s1;
    reg [5:0] s2;
    reg sck_d;
    reg cs_d;
    reg [2:0] st;
    reg [7:0] cmd;
    reg [7:0] sr;
    reg [2:0] bc;
    reg [1:0] acnt;
    reg [23:0] addr;
    reg [3:0] dcnt;
    reg got;
    reg prog_ok;
    reg quad_command_mode;
    reg write_enable_latch;
    reg busy;
    reg rst_en;
    reg [1:0] dummy;
    reg [1:0] wrap;
    reg [1:0] op;
    reg [15:0] tmr;
    reg [8:0] eidx;
    reg [1:0] esel;
    reg pwe;
    reg [9:0] pwa;
    reg [7:0] pwd;
    reg prod_on;
    reg [23:0] rd_addr;
    reg [1:0] rd_mode;
    reg [2:0] ocnt;
    reg [7:0] osr;
    reg [7:0] sec_mem [0:1023];

    wire [5:0] raw = {spi_io_i, spi_sck_i, spi_cs_n_i};
    wire cs_q = s2[0];
    wire sck_q = s2[1];
    wire [3:0] io_q = s2[5:2];
    wire sck_rise = sck_q & ~sck_d;
    wire sck_fall = ~sck_q & sck_d;
    wire cs_rise = cs_q & ~cs_d;
    wire [2:0] bc_n = bc + (quad_command_mode ? 3'h4 : 3'h1);
    wire byte_done = (bc_n == 3'h0);
    wire [7:0] nbyte = quad_command_mode ? {sr[3:0], io_q} : {sr[6:0], io_q[0]};
    wire [23:0] full = {addr[15:0], nbyte};
    wire [7:0] status = {6'h00, write_enable_latch, busy};
    wire f_ir;
    wire f_ov;
    wire [7:0] f_od;
    wire [7:0] f_in = (rd_mode == M_SEC) ? sec_mem[{rd_addr[13:12], rd_addr[7:0]}] : arr_data_i;
    wire [7:0] obyte = (cmd == `SOTP_OP_RDSR) ? status : (f_ov ? f_od : `SOTP_ERASED);
    wire out_go = sck_fall & ~cs_q & (st == ST_DOUT);
    wire pop = out_go & (ocnt == 3'h0) & (cmd != `SOTP_OP_RDSR);

    function sel_ok;
        input [23:0] a;
        begin
            sel_ok = (a[23:16] == `SOTP_SEC_HI) && (a[11:8] == `SOTP_SEC_MID) &&
                (a[15:12] == `SOTP_SEC_R1 || a[15:12] == `SOTP_SEC_R2 ||
                 a[15:12] == `SOTP_SEC_R3);
        end
    endfunction

    function locked;
        input [23:0] a;
        input [2:0] lb;
        begin
            locked = |(lb & (3'h1 << (a[13:12] - 2'h1)));
        end
    endfunction

    function [23:0] next_addr;
        input [23:0] a;
        input [1:0] mode;
        input [1:0] wl;
        reg [23:0] m;
        begin
            m = {18'h00000, (6'h08 << wl) - 6'h01};
            if (mode == M_SEC) begin
                next_addr = {a[23:8], a[7:0] + 8'h01};
            end else if (mode == M_WIN) begin
                next_addr = (a & ~m) | ((a + 24'h000001) & m);
            end else begin
                next_addr = a + 24'h000001;
            end
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_sync
            always @(posedge ref_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    s1[g] <= SYNC_INIT[g];
                    s2[g] <= SYNC_INIT[g];
                end else if (clk_en_i) begin
                    s1[g] <= raw[g];
                    s2[g] <= s1[g];
                end
            end
        end
    endgenerate

    sotp_fifo #(
        .WIDTH(`SOTP_FIFO_WIDTH),
        .DEPTH(`SOTP_FIFO_DEPTH),
        .AW(`SOTP_FIFO_AW)
    ) u_fifo (
        .clk_i(ref_clk_i),
        .reset_i(reset_i),
        .en_i(clk_en_i),
        .flush_i(cs_rise),
        .in_valid_i(prod_on),
        .in_ready_o(f_ir),
        .in_data_i(f_in),
        .out_valid_o(f_ov),
        .out_ready_i(pop),
        .out_data_o(f_od)
    );

    always @(posedge ref_clk_i) begin
        if (clk_en_i) begin
            if (!eidx[8]) begin
                sec_mem[{esel, eidx[7:0]}] <= `SOTP_ERASED;
            end else if (pwe) begin
                sec_mem[pwa] <= sec_mem[pwa] & pwd;
            end
        end
    end

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
            st <= ST_CMD;
            cmd <= 8'h00;
            sr <= 8'h00;
            bc <= 3'h0;
            acnt <= 2'h0;
            addr <= 24'h000000;
            dcnt <= 4'h0;
            got <= 1'b0;
            prog_ok <= 1'b0;
            quad_command_mode <= 1'b0;
            write_enable_latch <= 1'b0;
            busy <= 1'b0;
            rst_en <= 1'b0;
            dummy <= `SOTP_DUMMY_DEF;
            wrap <= `SOTP_WRAP_DEF;
            op <= OP_ERASE;
            tmr <= 16'h0000;
            eidx <= 9'h100;
            esel <= 2'h0;
            pwe <= 1'b0;
            pwa <= 10'h000;
            pwd <= 8'h00;
            prod_on <= 1'b0;
            rd_addr <= 24'h000000;
            rd_mode <= M_SEC;
            ocnt <= 3'h0;
            osr <= 8'h00;
            spi_io_o <= 4'h0;
        end else if (clk_en_i) begin
            sck_d <= sck_q;
            cs_d <= cs_q;
            pwe <= 1'b0;
            if (!eidx[8]) begin
                eidx <= eidx + 9'h001;
            end
            if (busy) begin
                if (tmr == 16'h0001) begin
                    busy <= 1'b0;
                    if (op != OP_RST) begin
                        write_enable_latch <= 1'b0;
                    end
                end else begin
                    tmr <= tmr - 16'h0001;
                end
            end
            if (prod_on && f_ir) begin
                rd_addr <= next_addr(rd_addr, rd_mode, wrap);
            end
            if (out_go) begin
                // data MSB first on falling edges
                if (ocnt == 3'h0) begin
                    spi_io_o <= quad_command_mode ? obyte[7:4] : {2'b00, obyte[7], 1'b0};
                    osr <= quad_command_mode ? {obyte[3:0], 4'h0} : {obyte[6:0], 1'b0};
                    ocnt <= quad_command_mode ? 3'h1 : 3'h7;
                end else begin
                    spi_io_o <= quad_command_mode ? osr[7:4] : {2'b00, osr[7], 1'b0};
                    osr <= quad_command_mode ? {osr[3:0], 4'h0} : {osr[6:0], 1'b0};
                    ocnt <= ocnt - 3'h1;
                end
            end
            if (cs_rise) begin
                st <= ST_CMD;
                bc <= 3'h0;
                acnt <= 2'h0;
                got <= 1'b0;
                prod_on <= 1'b0;
                ocnt <= 3'h0;
                spi_io_o <= 4'h0;
                rst_en <= (st == ST_DONE) && (cmd == `SOTP_OP_RSTEN);
                if (st == ST_DONE) begin
                    case (cmd)
                        `SOTP_OP_WREN: write_enable_latch <= 1'b1;
                        `SOTP_OP_WRDI: write_enable_latch <= 1'b0;
                        `SOTP_OP_QPI_EN: quad_command_mode <= quad_enable_bit_i;
                        `SOTP_OP_QPI_EX: quad_command_mode <= 1'b0;
                        `SOTP_OP_RST: begin
                            if (rst_en) begin
                                quad_command_mode <= 1'b0;
                                write_enable_latch <= 1'b0;
                                dummy <= `SOTP_DUMMY_DEF;
                                wrap <= `SOTP_WRAP_DEF;
                                busy <= 1'b1;
                                op <= OP_RST;
                                tmr <= T_RST[15:0];
                                eidx <= 9'h100;
                            end
                        end
                        `SOTP_OP_ERASE: begin
                            if (write_enable_latch && sel_ok(addr) && !locked(addr, otp_lock_bits_i)) begin
                                busy <= 1'b1;
                                op <= OP_ERASE;
                                tmr <= T_ERASE[15:0];
                                eidx <= 9'h000;
                                esel <= addr[13:12];
                            end
                        end
                        default: ;
                    endcase
                end
                if (st == ST_DIN && cmd == `SOTP_OP_PROG && got && bc == 3'h0 && prog_ok) begin
                    busy <= 1'b1;
                    op <= OP_PROG;
                    tmr <= T_PROG[15:0];
                end
            end else if (!cs_q && sck_rise) begin
                if (st == ST_CMD || st == ST_ADDR || st == ST_DIN) begin
                    sr <= nbyte;
                    bc <= bc_n;
                end
                case (st)
                    ST_CMD: begin
                        if (byte_done) begin
                            cmd <= nbyte;
                            if (busy && nbyte != `SOTP_OP_RDSR && nbyte != `SOTP_OP_RSTEN &&
                                nbyte != `SOTP_OP_RST) begin
                                st <= ST_IGN;
                            end else if (!quad_command_mode) begin
                                case (nbyte)
                                    `SOTP_OP_ERASE, `SOTP_OP_PROG, `SOTP_OP_READ,
                                    `SOTP_OP_BURST: st <= ST_ADDR;
                                    `SOTP_OP_QPI_EN, `SOTP_OP_WREN, `SOTP_OP_WRDI,
                                    `SOTP_OP_RSTEN, `SOTP_OP_RST: st <= ST_DONE;
                                    `SOTP_OP_RDSR: st <= ST_DOUT;
                                    default: st <= ST_IGN;
                                endcase
                            end else begin
                                case (nbyte)
                                    `SOTP_OP_RDPAR: st <= ST_DIN;
                                    `SOTP_OP_FREAD, `SOTP_OP_QREAD,
                                    `SOTP_OP_WRAPRD: st <= ST_ADDR;
                                    `SOTP_OP_QPI_EX, `SOTP_OP_WREN, `SOTP_OP_WRDI,
                                    `SOTP_OP_RSTEN, `SOTP_OP_RST: st <= ST_DONE;
                                    `SOTP_OP_RDSR: st <= ST_DOUT;
                                    default: st <= ST_IGN;
                                endcase
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (byte_done) begin
                            addr <= full;
                            acnt <= acnt + 2'h1;
                            if (acnt == `SOTP_ADDR_LAST) begin
                                acnt <= 2'h0;
                                rd_addr <= full;
                                case (cmd)
                                    `SOTP_OP_ERASE: st <= ST_DONE;
                                    `SOTP_OP_BURST: st <= ST_DIN;
                                    `SOTP_OP_PROG: begin
                                        st <= ST_DIN;
                                        prog_ok <= write_enable_latch && sel_ok(full) &&
                                            !locked(full, otp_lock_bits_i);
                                    end
                                    `SOTP_OP_READ: begin
                                        st <= ST_DUMMY;
                                        dcnt <= `SOTP_SEC_DUMMY;
                                        prod_on <= sel_ok(full);
                                        rd_mode <= M_SEC;
                                    end
                                    default: begin
                                        st <= ST_DUMMY;
                                        dcnt <= {1'b0, dummy, 1'b0} + 4'h2;
                                        prod_on <= 1'b1;
                                        rd_mode <= (cmd == `SOTP_OP_WRAPRD) ? M_WIN : M_LIN;
                                    end
                                endcase
                            end
                        end
                    end
                    ST_DUMMY: begin
                        dcnt <= dcnt - 4'h1;
                        if (dcnt == 4'h1) begin
                            st <= ST_DOUT;
                        end
                    end
                    ST_DIN: begin
                        if (byte_done) begin
                            if (cmd == `SOTP_OP_PROG) begin
                                got <= 1'b1;
                                pwe <= prog_ok;
                                pwa <= {addr[13:12], addr[7:0]};
                                pwd <= nbyte;
                                addr[7:0] <= addr[7:0] + 8'h01;
                            end else if (cmd == `SOTP_OP_BURST) begin
                                wrap <= nbyte[5:4];
                                st <= ST_DONE;
                            end else begin
                                dummy <= nbyte[5:4];
                                wrap <= nbyte[1:0];
                                st <= ST_DONE;
                            end
                        end
                    end
                    ST_DONE: st <= ST_IGN;
                    default: ;
                endcase
            end
        end
    end

    assign spi_io_oe_o = (st == ST_DOUT && !cs_q) ? (quad_command_mode ? 4'hF : 4'h2) : 4'h0;
    assign arr_addr_o = rd_addr;
    assign arr_rd_o = prod_on & (rd_mode != M_SEC);
    assign busy_o = busy;
    assign write_enable_latch_o = write_enable_latch;
    assign quad_command_mode_o = quad_command_mode;
    assign dummy_count_field_o = dummy;
    assign wrap_len_field_o = wrap;
endmodule

// ===== tb/sotp_core_props.sv
// Purpose: Port-level checks for the security register command block.
// Assumes: One clock domain; sees only the top module's ports.
// Notes: Attached by a bind in the testbench file.
module sotp_core_props (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // Link side and quad enable bit
    input wire spi_cs_n_i,
    input wire [3:0] spi_io_oe_o,
    input wire quad_enable_bit_i,
    // Block state
    input wire busy_o,
    input wire write_enable_latch_o,
    input wire quad_command_mode_o,
    input wire [1:0] dummy_count_field_o,
    input wire [1:0] wrap_len_field_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BUSY_LAST = 994;
    default clocking dc @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_busy_min;
        busy_o [*8];
    endsequence
    sequence s_cs_idle;
        spi_cs_n_i [*5];
    endsequence
    AST_DEFAULTS: assert property ($fell(reset_i) |->
        !quad_command_mode_o && !busy_o && dummy_count_field_o == 2'h0 && wrap_len_field_o == 2'h0)
        else $error("state after reset is not the default");
    AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
        else $error("busy rose without chip select high");
    AST_BUSY_SPAN: assert property ($rose(busy_o) |-> s_busy_min ##[1:BUSY_LAST] !busy_o)
        else $error("busy too short or too long");
    AST_WEL_DONE: assert property ($fell(busy_o) |-> !write_enable_latch_o)
        else $error("write latch still set after cycle end");
    AST_QUAD_GATE: assert property ($rose(quad_command_mode_o) |-> quad_enable_bit_i)
        else $error("quad mode entered while not enabled");
    AST_SWITCH_KEEP: assert property ($rose(quad_command_mode_o) |->
        $stable(wrap_len_field_o) && $stable(write_enable_latch_o))
        else $error("mode switch changed latch or wrap");
    AST_DUMMY_QUAD: assert property ($changed(dummy_count_field_o) |->
        $past(quad_command_mode_o) || dummy_count_field_o == 2'h0)
        else $error("dummy field changed outside quad mode");
    AST_OE_IDLE: assert property (s_cs_idle |-> spi_io_oe_o == 4'h0)
        else $error("data driven while not selected");
endmodule

// ===== tb/sotp_host_model.sv
// Purpose: Host controller model driving the serial link.
// Assumes: Mode 0 link clock of 400 ns, stopped low between frames.
// Notes: Read bits are taken just before each rising link edge.
module sotp_host_model (
    // Link pins
    output logic spi_cs_n_o,
    output logic spi_sck_o,
    output logic [3:0] spi_io_o,
    input wire [3:0] spi_io_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx[$];
    initial begin
        spi_cs_n_o = 1'b1;
        spi_sck_o = 1'b0;
        spi_io_o = 4'h5;
    end
    task automatic tick(input logic [3:0] d, output logic [3:0] s);
        spi_io_o = d;
        #200;
        s = spi_io_i;
        spi_sck_o = 1'b1;
        #200;
        spi_sck_o = 1'b0;
    endtask
    task automatic send(input bit q, input int n, input logic [47:0] w,
                        input int nd = 0, input int nrd = 0, input int cut = 0);
        logic [3:0] s;
        logic [7:0] b;
        int bits;
        bits = q ? 2 : 8;
        rx = {};
        spi_cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            b = w[8*i +: 8];
            for (int k = 0; k < bits; k++) begin
                tick(q ? b[7-4*k -: 4] : {3'h0, b[7-k]}, s);
            end
        end
        repeat (cut + nd) tick(4'hA, s);
        for (int i = 0; i < nrd; i++) begin
            for (int k = 0; k < bits; k++) begin
                tick(4'h0, s);
                b = q ? {b[3:0], s} : {b[6:0], s[1]};
            end
            rx.push_back(b);
        end
        #200;
        spi_cs_n_o = 1'b1;
        spi_io_o = ~spi_io_o;
        #400;
    endtask
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the security register command block.
// Assumes: Main array data equals the low address byte.
// Notes: All stimulus and checks land 5 ns after a clock edge.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic quad_enable_bit = 1'b0;
    logic clk_en = 1'b1;
    logic arr_seen = 1'b0;
    logic [2:0] otp_lock_bits = 3'h0;
    wire cs_n, sck, busy, write_enable_latch, quad, arr_rd;
    wire [1:0] dummy, wrap;
    wire [3:0] host_io, dev_io, dev_oe, link_io;
    wire [23:0] arr_addr;
    int n_mismatch = 0;
    int checks_done = 0;
    assign link_io = (dev_oe & dev_io) | (~dev_oe & host_io);
    always #25 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i) begin
        if (arr_rd === 1'b1) begin
            arr_seen <= 1'b1;
        end
    end
    sotp_core dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
        .spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_io_i(link_io), .spi_io_o(dev_io),
        .spi_io_oe_o(dev_oe), .quad_enable_bit_i(quad_enable_bit),
        .otp_lock_bits_i(otp_lock_bits), .arr_addr_o(arr_addr), .arr_rd_o(arr_rd),
        .arr_data_i(arr_addr[7:0]), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
        .quad_command_mode_o(quad), .dummy_count_field_o(dummy), .wrap_len_field_o(wrap)
    );
    sotp_host_model host_u (
        .spi_cs_n_o(cs_n), .spi_sck_o(sck), .spi_io_o(host_io), .spi_io_i(link_io)
    );
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic state(input logic [7:0] exp);
        chk("state", exp, {1'b0, quad, busy, write_enable_latch, dummy, wrap});
    endtask
    task automatic expect_rx(input int n, input logic [31:0] e);
        for (int i = 0; i < n; i++) begin
            chk("read byte", e[8*(n-1-i) +: 8], host_u.rx[i]);
        end
    endtask
    task automatic wait_idle(input int lim);
        for (int n = 0; busy !== 1'b0; n++) begin
            if (n == lim) begin
                chk("busy end", 8'h00, 8'h01);
                complete_run();
            end
            @(posedge ref_clk_i);
            #5;
        end
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_i);
        #5;
        reset_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #5;
        state(8'h00);
        host_u.send(0, 4, 48'h44001000); // without latch
        state(8'h00);
        host_u.send(0, 1, 48'h06);
        host_u.send(0, 1, 48'h04);
        host_u.send(0, 4, 48'h44001000); // latch withdrawn
        state(8'h00);
        host_u.send(0, 1, 48'h06);
        host_u.send(0, 4, 48'h44001000, 0, 0, 1); // extra bit
        state(8'h10);
        host_u.send(0, 4, 48'h44001000); // erase one
        state(8'h30);
        host_u.send(0, 1, 48'h05, 0, 1); // status poll
        expect_rx(1, 32'h03);
        wait_idle(1100);
        state(8'h00);
        clk_en = 1'b0;
        host_u.send(0, 1, 48'h06); // frozen, ignored
        clk_en = 1'b1;
        state(8'h00);
        host_u.send(0, 1, 48'h06);
        host_u.send(0, 6, 48'h420010FE3CA5); // two bytes
        wait_idle(300);
        host_u.send(0, 1, 48'h06);
        host_u.send(0, 5, 48'h420010FE0F); // over a written byte
        wait_idle(300);
        host_u.send(0, 5, 48'h4200100000); // without latch
        state(8'h00);
        host_u.send(0, 4, 48'h480010FE, 8, 3);
        expect_rx(3, 32'h0CA5FF);
        otp_lock_bits = 3'h1;
        host_u.send(0, 1, 48'h06);
        host_u.send(0, 4, 48'h44001000); // locked erase
        host_u.send(0, 5, 48'h42001000C3); // locked program
        state(8'h10);
        host_u.send(0, 4, 48'h480010FF, 8, 2);
        expect_rx(2, 32'hA5FF);
        host_u.send(0, 4, 48'h48004000, 8, 1);
        expect_rx(1, 32'hFF);
        host_u.send(0, 2, 48'hC033); // refused
        host_u.send(0, 5, 48'h7700000020); // wrap field
        state(8'h12);
        host_u.send(0, 1, 48'h38); // not enabled
        state(8'h12);
        quad_enable_bit = 1'b1;
        host_u.send(0, 1, 48'h38); // enter
        state(8'h52);
        for (int c = 0; c < 4; c++) begin
            host_u.send(1, 2, {32'h0, 8'hC0, 2'h0, c[1:0], 2'h0, c[1:0]});
            state({4'h5, c[1:0], c[1:0]});
        end
        chk("array read", 8'h00, {7'h00, arr_seen});
        host_u.send(1, 2, 48'hC011);
        host_u.send(1, 4, 48'h0C00000E, 4, 4);
        expect_rx(4, 32'h0E0F0001);
        chk("array read", 8'h01, {7'h00, arr_seen});
        host_u.send(1, 1, 48'h66);
        host_u.send(1, 1, 48'h99);
        wait_idle(700);
        state(8'h00);
        complete_run();
    end
endmodule
bind sotp_core sotp_core_props chk_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .spi_cs_n_i(spi_cs_n_i),
    .spi_io_oe_o(spi_io_oe_o), .quad_enable_bit_i(quad_enable_bit_i), .busy_o(busy_o),
    .write_enable_latch_o(write_enable_latch_o), .quad_command_mode_o(quad_command_mode_o),
    .dummy_count_field_o(dummy_count_field_o), .wrap_len_field_o(wrap_len_field_o)
);
